// ===== design/rdq_pkg.sv
// Purpose: shared constants and types of the receive done-queue writer
// Assumes: AXI4-Lite register access with 32-bit data and 16-bit addresses
// Notes: address, pointer, timer and control registers are 16 bits wide in the low half of a word; status, irq enable and config are narrower
package rdq_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADR_BASE_LOW = 16'h0730;
   localparam logic [15:0] ADR_BASE_HIGH = 16'h0734;
   localparam logic [15:0] ADR_END_INDEX = 16'h0738;
   localparam logic [15:0] ADR_HOST_READ_PTR = 16'h073c;
   localparam logic [15:0] ADR_DMA_WRITE_PTR = 16'h0740;
   localparam logic [15:0] ADR_FLUSH_TIMER = 16'h0744;
   localparam logic [15:0] ADR_DMA_STATUS = 16'h0750;
   localparam logic [15:0] ADR_IRQ_ENABLE = 16'h0754;
   localparam logic [15:0] ADR_MASTER_CFG = 16'h0758;
   localparam logic [15:0] ADR_QUEUE_CTRL = 16'h0780;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int QCTRL_THR_LSB = 8;         // post_status_threshold, 3 bits
   localparam int STAT_POST_BIT = 0;         // done_post_status_flag
   localparam int STAT_ERR_BIT = 1;          // done_post_error_flag
   localparam int CFG_RX_EN_BIT = 0;         // rx_dma_enable_bit
   localparam int DESC_CHAN_LSB = 16;
   localparam int DESC_FILLED_BUFFER_COUNT_LSB = 24;
   localparam int DESC_STATUS_LSB = 27;
   localparam int DESC_EOF_BIT = 30;
   localparam int DESC_VALID_BIT = 31;

   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [15:0] PTR_WRAP = 16'h0000;
   localparam logic [2:0] THR_AT_END = 3'h0;     // post only at packet end
   localparam logic [2:0] FILLED_BUFFER_COUNT_WHOLE = 3'h0;
   localparam logic [2:0] PSTAT_RESERVED = 3'h7; // never produced
   localparam logic [2:0] PSTAT_PCI_ABORT = 3'h6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   // one filled receive buffer; eof marks the last buffer of a packet
   typedef struct packed {
      logic [15:0] desc_index;   // relative to receive descriptor base
      logic [7:0] channel;       // channel number minus one
      logic [2:0] chan_thr;      // channel_post_threshold of this channel
      logic eof;
      logic [2:0] pkt_status;
   } rdq_event_t;

   // one dword write into host memory
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } rdq_mwr_t;

   typedef enum logic [0:0] {ST_IDLE, ST_WRITE} rdq_state_e_t;

   typedef struct packed {
      // register bus
      logic aw_ready;
      logic w_ready;
      logic aw_held;
      logic w_held;
      logic [15:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic b_valid;
      logic [1:0] b_resp;
      logic ar_ready;
      logic r_valid;
      logic [31:0] r_data;
      logic [1:0] r_resp;
      // registers
      logic [15:0] base_low;
      logic [15:0] base_high;
      logic [15:0] end_index;
      logic [15:0] host_read_ptr;
      logic [15:0] dma_write_ptr;
      logic [15:0] flush_timer;
      logic [15:0] queue_ctrl;
      logic [1:0] status;
      logic [1:0] irq_en;
      logic rx_en;
      logic irq;
      // posting engine
      logic ev_ready;
      rdq_state_e_t st;
      logic [7:0] write_count;
      logic mw_valid;
      rdq_mwr_t mw;
   } rdq_state_t;

   localparam rdq_state_t RDQ_STATE_RST = '0;

endpackage

// ===== design/rdq_writer.sv
// Purpose: posts one-dword completion descriptors into a circular done queue
// Assumes: one clock; host memory writes leave through a valid/ready port
// Notes: per-channel buffer counts are held in a local 256-entry array
`timescale 1ns/1ps

module rdq_writer
   import rdq_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus write address
   input wire logic [15:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // register bus write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // register bus write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // register bus read address
   input wire logic [15:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // register bus read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // filled-buffer events from the receive dma
   input wire rdq_event_t ev,
   input wire logic ev_valid,
   output logic ev_ready,
   // descriptor writes toward host memory
   output rdq_mwr_t mw,
   output logic mw_valid,
   input wire logic mw_ready,
   // interrupt request
   output logic irq
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // byte-lane merge for a 16-bit register in the low half of a word
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   // pointer after one dword, wrapped once it passes the end index
   function automatic logic [15:0] ptr_advance(input logic [15:0] ptr,
                                               input logic [15:0] end_idx);
      logic [16:0] inc;
      inc = {1'b0, ptr} + 17'h00001;
      if (inc > {1'b0, end_idx}) begin
         return PTR_WRAP;
      end
      return inc[15:0];
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   rdq_state_t s;
   rdq_state_t next_s;
   logic [2:0] chan_count [0:255];
   logic cnt_we;
   logic [7:0] cnt_addr;
   logic [2:0] cnt_wdata;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic [1:0] stat_set;
      logic [1:0] stat_clr;
      logic [2:0] new_count;
      logic post;
      logic [2:0] filled_buffer_count;
      logic [15:0] wp_next;
      logic [7:0] need;
      logic [31:0] base;
      logic do_write;
      stat_set = 2'h0;
      stat_clr = 2'h0;
      new_count = 3'h0;
      post = 1'b0;
      filled_buffer_count = FILLED_BUFFER_COUNT_WHOLE;
      wp_next = 16'h0000;
      need = 8'h00;
      base = {s.base_high, s.base_low};
      do_write = 1'b0;
      cnt_we = 1'b0;
      cnt_addr = ev.channel;
      cnt_wdata = 3'h0;
      next_s = s;

      // write channel: address and data taken in either order
      if (s_axi_awvalid && s.aw_ready) begin
         next_s.aw_ready = 1'b0;
         next_s.aw_held = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.w_ready) begin
         next_s.w_ready = 1'b0;
         next_s.w_held = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb = s_axi_wstrb;
      end
      if (!s.aw_held && !s.aw_ready && !s.b_valid && !(s_axi_awvalid && s.aw_ready)) begin
         next_s.aw_ready = 1'b1;
      end
      if (!s.w_held && !s.w_ready && !s.b_valid && !(s_axi_wvalid && s.w_ready)) begin
         next_s.w_ready = 1'b1;
      end
      if (s.aw_held && s.w_held && !s.b_valid) begin
         do_write = 1'b1;
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.b_valid = 1'b1;
         next_s.b_resp = RESP_OKAY;
      end
      if (s.b_valid && s_axi_bready) begin
         next_s.b_valid = 1'b0;
         next_s.aw_ready = 1'b1;
         next_s.w_ready = 1'b1;
      end

      // register writes
      if (do_write) begin
         unique case (s.aw_addr)
            ADR_BASE_LOW: next_s.base_low = merge16(s.base_low, s.w_data, s.w_strb);
            ADR_BASE_HIGH: next_s.base_high = merge16(s.base_high, s.w_data, s.w_strb);
            ADR_END_INDEX: next_s.end_index = merge16(s.end_index, s.w_data, s.w_strb);
            ADR_HOST_READ_PTR: begin
               next_s.host_read_ptr = merge16(s.host_read_ptr, s.w_data, s.w_strb);
            end
            ADR_DMA_WRITE_PTR: begin
               // host may seed the pointer only while the dma is stopped
               if (!s.rx_en) begin
                  next_s.dma_write_ptr = merge16(s.dma_write_ptr, s.w_data, s.w_strb);
               end
            end
            ADR_FLUSH_TIMER: next_s.flush_timer = merge16(s.flush_timer, s.w_data, s.w_strb);
            ADR_QUEUE_CTRL: next_s.queue_ctrl = merge16(s.queue_ctrl, s.w_data, s.w_strb);
            ADR_DMA_STATUS: begin
               if (s.w_strb[0]) begin
                  stat_clr = s.w_data[1:0]; // write one to clear
               end
            end
            ADR_IRQ_ENABLE: begin
               if (s.w_strb[0]) begin
                  next_s.irq_en = s.w_data[1:0];
               end
            end
            ADR_MASTER_CFG: begin
               if (s.w_strb[0]) begin
                  next_s.rx_en = s.w_data[CFG_RX_EN_BIT];
               end
            end
            default: next_s.b_resp = RESP_SLVERR;
         endcase
      end

      // read channel
      if (s.r_valid && s_axi_rready) begin
         next_s.r_valid = 1'b0;
         next_s.ar_ready = 1'b1;
      end else if (!s.r_valid && !s.ar_ready) begin
         next_s.ar_ready = 1'b1;
      end
      if (s_axi_arvalid && s.ar_ready) begin
         next_s.ar_ready = 1'b0;
         next_s.r_valid = 1'b1;
         next_s.r_resp = RESP_OKAY;
         next_s.r_data = 32'h00000000;
         unique case (s_axi_araddr)
            ADR_BASE_LOW: next_s.r_data[15:0] = s.base_low;
            ADR_BASE_HIGH: next_s.r_data[15:0] = s.base_high;
            ADR_END_INDEX: next_s.r_data[15:0] = s.end_index;
            ADR_HOST_READ_PTR: next_s.r_data[15:0] = s.host_read_ptr;
            ADR_DMA_WRITE_PTR: next_s.r_data[15:0] = s.dma_write_ptr;
            ADR_FLUSH_TIMER: next_s.r_data[15:0] = s.flush_timer;
            ADR_QUEUE_CTRL: next_s.r_data[15:0] = s.queue_ctrl;
            ADR_DMA_STATUS: next_s.r_data[1:0] = s.status;
            ADR_IRQ_ENABLE: next_s.r_data[1:0] = s.irq_en;
            ADR_MASTER_CFG: next_s.r_data[CFG_RX_EN_BIT] = s.rx_en;
            default: next_s.r_resp = RESP_SLVERR;
         endcase
      end

      // posting engine
      unique case (s.st)
         ST_IDLE: begin
            if (ev_valid && s.ev_ready) begin
               new_count = chan_count[ev.channel] + 3'h1;
               if (ev.chan_thr == THR_AT_END) begin
                  post = ev.eof;
                  filled_buffer_count = FILLED_BUFFER_COUNT_WHOLE;
               end else begin
                  // a short packet posts fewer buffers than its threshold
                  post = ev.eof || (new_count == ev.chan_thr);
                  filled_buffer_count = new_count;
               end
               cnt_we = 1'b1;
               cnt_wdata = (post || ev.chan_thr == THR_AT_END) ? 3'h0 : new_count;
               if (post) begin
                  wp_next = ptr_advance(s.dma_write_ptr, s.end_index);
                  if (wp_next == s.host_read_ptr) begin
                     stat_set[STAT_ERR_BIT] = 1'b1;
                  end else begin
                     next_s.st = ST_WRITE;
                     next_s.mw_valid = 1'b1;
                     next_s.mw.addr = base + {14'h0000, s.dma_write_ptr, 2'b00};
                     next_s.mw.data = 32'h00000000;
                     next_s.mw.data[15:0] = ev.desc_index;
                     next_s.mw.data[DESC_CHAN_LSB +: 8] = ev.channel;
                     next_s.mw.data[DESC_FILLED_BUFFER_COUNT_LSB +: 3] = filled_buffer_count;
                     // status only means something on the last descriptor
                     if (ev.eof) begin
                        next_s.mw.data[DESC_STATUS_LSB +: 3] =
                           (ev.pkt_status == PSTAT_RESERVED) ? PSTAT_PCI_ABORT : ev.pkt_status;
                     end
                     next_s.mw.data[DESC_EOF_BIT] = ev.eof;
                     next_s.mw.data[DESC_VALID_BIT] = 1'b0;
                     // same lane order whatever the data endianness
                  end
               end
            end
         end
         ST_WRITE: begin
            if (mw_ready) begin
               next_s.mw_valid = 1'b0;
               next_s.st = ST_IDLE;
               next_s.dma_write_ptr = ptr_advance(s.dma_write_ptr, s.end_index);
               need = 8'h01 << s.queue_ctrl[QCTRL_THR_LSB +: 3];
               if (s.write_count + 8'h01 >= need) begin
                  stat_set[STAT_POST_BIT] = 1'b1;
                  next_s.write_count = 8'h00;
               end else begin
                  next_s.write_count = s.write_count + 8'h01;
               end
            end
         end
      endcase

      // ready needs idle and receive enable; it drops for one cycle after each event taken in idle, and stays low while a posted write waits for mw_ready
      next_s.ev_ready = (next_s.st == ST_IDLE) && next_s.rx_en
                        && !(ev_valid && s.ev_ready && s.st == ST_IDLE);

      // status: a set in the clearing cycle wins
      next_s.status = (s.status & ~stat_clr) | stat_set;
      next_s.irq = |(next_s.status & next_s.irq_en);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= RDQ_STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // per-channel filled-buffer counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 256; i++) begin
            chan_count[i] <= 3'h0;
         end
      end else if (cnt_we) begin
         chan_count[cnt_addr] <= cnt_wdata;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = s.aw_ready;
   assign s_axi_wready = s.w_ready;
   assign s_axi_bvalid = s.b_valid;
   assign s_axi_bresp = s.b_resp;
   assign s_axi_arready = s.ar_ready;
   assign s_axi_rvalid = s.r_valid;
   assign s_axi_rdata = s.r_data;
   assign s_axi_rresp = s.r_resp;
   assign ev_ready = s.ev_ready;
   assign mw = s.mw;
   assign mw_valid = s.mw_valid;
   assign irq = s.irq;

endmodule

// ===== verification/rdq_writer_assertions.sv
// Purpose: port checks of descriptor posting and register bus answers
// Assumes: sees only the writer ports; one clock domain
// Notes: queue pointers are internal, so full cases are judged by the bench
`timescale 1ns/1ps
module rdq_writer_assertions
   import rdq_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // events and descriptor writes
   input wire rdq_event_t ev,
   input wire logic ev_valid,
   input wire logic ev_ready,
   input wire rdq_mwr_t mw,
   input wire logic mw_valid,
   input wire logic mw_ready
);
   // ----------------------------------------------------------------
   // posting steps
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_take;
      ev_valid && ev_ready;
   endsequence
   sequence s_post;
      $rose(mw_valid);
   endsequence
   // a descriptor only ever follows a taken event
   a_post_cause: assert property (s_post |-> $past(ev_valid && ev_ready))
      else $error("descriptor posted without a taken event");
   a_index_chan: assert property (s_take ##1 s_post |-> mw.data[15:0] == $past(ev.desc_index)
      && mw.data[23:16] == $past(ev.channel))
      else $error("descriptor index or channel differs from event");
   a_filled_buffer_count_zero: assert property (s_take ##1 s_post ##0 $past(ev.chan_thr) == 3'h0
      |-> mw.data[26:24] == 3'h0)
      else $error("buffer count not zero for threshold zero");
   a_filled_buffer_count_range: assert property (s_take ##1 s_post ##0 $past(ev.chan_thr) != 3'h0
      |-> mw.data[26:24] != 3'h0 && mw.data[26:24] <= $past(ev.chan_thr))
      else $error("buffer count outside one to threshold");
   a_eof_flag: assert property (s_take ##1 s_post |-> mw.data[30] == $past(ev.eof))
      else $error("end flag differs from event");
   a_status_code: assert property (mw_valid |-> mw.data[29:27] != 3'h7
      && (mw.data[30] || mw.data[29:27] == 3'h0))
      else $error("packet status code illegal");
   a_valid_clear: assert property (mw_valid |-> !mw.data[31])
      else $error("descriptor written with valid set");
   a_mw_hold: assert property (mw_valid && !mw_ready |=> mw_valid && $stable(mw))
      else $error("descriptor write changed before taken");
   // bus answers, latencies as handed over
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
endmodule

bind rdq_writer rdq_writer_assertions chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .ev(ev), .ev_valid(ev_valid), .ev_ready(ev_ready),
   .mw(mw), .mw_valid(mw_valid), .mw_ready(mw_ready));

// ===== verification/rdq_host_mem.sv
// Purpose: host memory behind the descriptor write port
// Assumes: one dword per accepted write
// Notes: ready stalls in a fixed pseudo-random pattern
`timescale 1ns/1ps
module rdq_host_mem
   import rdq_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // descriptor writes
   input wire rdq_mwr_t mw,
   input wire logic mw_valid,
   output logic mw_ready
);
   logic [7:0] lfsr;
   logic [31:0] mem [0:255];
   // stalls, since real memory is not always ready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lfsr <= 8'h5a;
         mw_ready <= 1'b0;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         mw_ready <= lfsr[0] | lfsr[2];
      end
   end
   // polling host marks each entry read; the write pointer is left alone
   always_ff @(posedge aclk) begin
      if (mw_valid && mw_ready) begin
         mem[mw.addr[9:2]] <= mw.data | 32'h8000_0000;
      end
   end
endmodule

// ===== verification/rdq_writer_tb.sv
// Purpose: self-checking bench of the done-queue writer
// Assumes: host memory model on the write port
// Notes: a reference model in the driver predicts every descriptor
`timescale 1ns/1ps
module rdq_writer_tb
   import rdq_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ev_valid;
   logic awready, wready, bvalid, arready, rvalid, ev_ready, mw_valid, mw_ready, irq;
   logic [15:0] awaddr, araddr, wp, rp, endi;
   logic [31:0] wdata, rdata, seed;
   logic [1:0] bresp, rresp, stat, ien;
   logic [2:0] code;
   rdq_event_t ev;
   rdq_mwr_t mw;
   logic [63:0] mq[$];
   logic [33:0] rq[$];
   logic [3:0] cnt [0:255];
   int wc, err_total, comparisons, i;
   localparam logic [31:0] BASE = 32'habcd_4000;

   rdq_writer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ev(ev), .ev_valid(ev_valid),
      .ev_ready(ev_ready), .mw(mw), .mw_valid(mw_valid), .mw_ready(mw_ready), .irq(irq));
   rdq_host_mem mem_u (.aclk(aclk), .aresetn(aresetn), .mw(mw), .mw_valid(mw_valid),
      .mw_ready(mw_ready));

   // ----------------------------------------------------------------
   // clock, compare and closing
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   task automatic report(input logic [63:0] g, input logic [63:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_mw(input logic [63:0] g, input logic [63:0] e);
      report(g, e);
   endtask
   task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
      report(64'(g), 64'(e));
   endtask
   task automatic chk_bit(input logic g, input logic e);
      report(64'(g), 64'(e));
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   // ----------------------------------------------------------------
   // bus and event drivers
   // ----------------------------------------------------------------
   // each channel released at its own handshake, answer expected via queue
   task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] rs);
      logic pa, pw, pb;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      rq.push_back({rs, 32'h0});
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pa || pw || pb) begin
         @(negedge aclk);
         pa = pa && !awready;
         pw = pw && !wready;
         pb = pb && !bvalid;
         @(posedge aclk);
         awvalid <= pa;
         wvalid <= pw;
         bready <= pb;
      end
   endtask
   task automatic axi_rd(input logic [15:0] a, input logic [33:0] e);
      logic pa, pr;
      pa = 1'b1;
      pr = 1'b1;
      rq.push_back(e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (pa || pr) begin
         @(negedge aclk);
         pa = pa && !arready;
         pr = pr && !rvalid;
         @(posedge aclk);
         arvalid <= pa;
         rready <= pr;
      end
   endtask
   // channel threshold is the low channel bits, so it never changes per channel
   task automatic send_ev(input logic [7:0] ch, input logic e, input logic [2:0] ps,
      input logic [15:0] di);
      logic post, tk;
      logic [15:0] nx;
      logic [2:0] bc;
      cnt[ch] = cnt[ch] + 4'h1;
      post = e || (ch[2:0] != 3'h0 && cnt[ch][2:0] == ch[2:0]);
      bc = (ch[2:0] == 3'h0) ? 3'h0 : cnt[ch][2:0];
      if (post) begin
         cnt[ch] = 4'h0;
         nx = (wp + 16'h1 > endi) ? 16'h0 : wp + 16'h1;
         if (nx == rp) begin
            stat[1] = 1'b1;
         end else begin
            mq.push_back({BASE + {14'h0, wp, 2'b00}, 1'b0, e,
               e ? ((ps == 3'h7) ? 3'h6 : ps) : 3'h0, bc, ch, di});
            wp = nx;
            wc++;
            if (wc >= (1 << code)) begin
               stat[0] = 1'b1;
               wc = 0;
            end
         end
      end
      @(posedge aclk);
      ev <= '{desc_index: di, channel: ch, chan_thr: ch[2:0], eof: e, pkt_status: ps};
      ev_valid <= 1'b1;
      tk = 1'b0;
      while (!tk) begin
         @(negedge aclk);
         tk = ev_ready;
         @(posedge aclk);
      end
      ev_valid <= 1'b0;
      @(negedge aclk);
      while (!ev_ready) @(negedge aclk);
   endtask

   // ----------------------------------------------------------------
   // monitor and watchdog
   // ----------------------------------------------------------------
   always @(negedge aclk) begin
      if (mw_valid && mw_ready) chk_mw(mw, (mq.size() > 0) ? mq.pop_front() : 64'hx);
      if (rvalid && rready) chk_rd({rresp, rdata}, (rq.size() > 0) ? rq.pop_front() : 34'hx);
      if (bvalid && bready) chk_rd({bresp, 32'h0}, (rq.size() > 0) ? rq.pop_front() : 34'hx);
   end
   initial begin
      #(50 * 30000);
      err_total++;
      end_sim();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, ev_valid} = 7'h0;
      {awaddr, araddr, wdata, ev} = '0;
      {wp, rp, endi, stat, ien, code} = '0;
      {wc, err_total, comparisons} = '0;
      seed = 32'd79;
      for (i = 0; i < 256; i++) cnt[i] = 4'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i++) axi_rd(ADR_BASE_LOW + 16'(i * 4), {RESP_OKAY, 32'h0});
      axi_rd(16'h07fc, {RESP_SLVERR, 32'h0});
      axi_wr(16'h07fc, 32'h1, RESP_SLVERR);
      $display("test reset done");
      axi_wr(ADR_BASE_LOW, 32'h4000, RESP_OKAY);
      axi_wr(ADR_BASE_HIGH, 32'habcd, RESP_OKAY);
      axi_wr(ADR_END_INDEX, 32'hf, RESP_OKAY);
      endi = 16'hf;
      axi_wr(ADR_QUEUE_CTRL, 32'h200, RESP_OKAY);
      code = 3'h2;
      axi_wr(ADR_IRQ_ENABLE, 32'h3, RESP_OKAY);
      ien = 2'h3;
      // an offered event must wait for receive enable
      @(posedge aclk);
      ev_valid <= 1'b1;
      repeat (4) @(negedge aclk);
      chk_bit(ev_ready, 1'b0);
      @(posedge aclk);
      ev_valid <= 1'b0;
      axi_wr(ADR_MASTER_CFG, 32'h1, RESP_OKAY);
      // random traffic; the host drains before the queue fills
      for (i = 0; i < 60; i++) begin
         if (((wp - rp) & 16'hf) >= 16'd10) begin
            axi_wr(ADR_HOST_READ_PTR, {16'h0, wp}, RESP_OKAY);
            rp = wp;
         end
         seed = xs(seed);
         send_ev(seed[7] ? {5'h1f, seed[2:0]} : {5'h0, seed[2:0]}, seed[9:8] == 2'h0,
            seed[12:10], seed[31:16]);
      end
      axi_rd(ADR_DMA_STATUS, {RESP_OKAY, 30'h0, stat});
      axi_wr(ADR_DMA_STATUS, 32'h3, RESP_OKAY);
      stat = 2'h0;
      axi_wr(ADR_QUEUE_CTRL, 32'h0, RESP_OKAY);
      code = 3'h0;
      axi_wr(ADR_DMA_WRITE_PTR, 32'h5, RESP_OKAY);
      axi_rd(ADR_DMA_WRITE_PTR, {RESP_OKAY, 16'h0, wp});
      $display("test random done");
      // small queue: wrap, full refusal, host frees a slot
      axi_wr(ADR_END_INDEX, 32'h3, RESP_OKAY);
      endi = 16'h3;
      axi_wr(ADR_HOST_READ_PTR, 32'h2, RESP_OKAY);
      rp = 16'h2;
      for (i = 0; i < 6; i++) begin
         if (i == 3) begin
            axi_wr(ADR_HOST_READ_PTR, 32'h3, RESP_OKAY);
            rp = 16'h3;
         end
         send_ev(8'h00, 1'b1, 3'(i), 16'(i));
      end
      axi_rd(ADR_DMA_STATUS, {RESP_OKAY, 30'h0, stat});
      axi_rd(ADR_DMA_WRITE_PTR, {RESP_OKAY, 16'h0, wp});
      $display("test full done");
      // interrupt raised, masked, cleared
      @(negedge aclk);
      chk_bit(irq, |(stat & ien));
      axi_wr(ADR_DMA_STATUS, 32'h1, RESP_OKAY);
      stat[0] = 1'b0;
      axi_wr(ADR_IRQ_ENABLE, 32'h1, RESP_OKAY);
      @(negedge aclk);
      chk_bit(irq, 1'b0);
      axi_wr(ADR_IRQ_ENABLE, 32'h2, RESP_OKAY);
      @(negedge aclk);
      chk_bit(irq, stat[1]);
      axi_wr(ADR_DMA_STATUS, 32'h3, RESP_OKAY);
      @(negedge aclk);
      chk_bit(irq, 1'b0);
      chk_bit(mq.size() == 0, 1'b1);
      $display("test irq done");
      end_sim();
   end
endmodule
